// ===== verilog/remote_trigger_pkg.sv
// Purpose: Shared constants and carrier types of the remote trigger and serial port.
// Assumes: 100 MHz system clock.
// Notes: Long counts live as top-level parameters so a simulation can shorten them.
package remote_trigger_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_BPS = 9600;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_BPS;

    // Gate periods of the internal gate settings, in milliseconds.
    localparam int GATE_SHORT_MS = 100;
    localparam int GATE_LONG_MS = 1000;
    localparam int GATE_SHORT_CYCLES_DEF = GATE_SHORT_MS * (CLK_HZ / 1000);
    localparam int GATE_LONG_CYCLES_DEF = GATE_LONG_MS * (CLK_HZ / 1000);

    // Width of the gate sync pulse, in microseconds.
    localparam int SYNC_PULSE_US = 10;
    localparam int SYNC_PULSE_CYCLES = SYNC_PULSE_US * (CLK_HZ / 1_000_000);

    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_LF = 8'h0a;
    localparam logic [7:0] RC_OK = 8'h30;
    localparam int MNEM_LEN = 3;
    localparam logic [7:0] LINE_LEN_MAX = 8'hff;

    localparam int SAMPLE_W = 24;
    localparam int COUNT_W = 24;

    typedef enum logic [1:0] {
        GATE_SHORT,
        GATE_LONG,
        GATE_EXT
    } gate_setting_t;

    typedef struct packed {
        logic [MNEM_LEN*8-1:0] mnemonic;
        logic has_param;
    } command_t;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] value;
        logic forced_zero;
    } reading_t;

endpackage

// ===== verilog/serial_rx_core.sv
// Purpose: 8N1 receiver for the host serial port.
// Assumes: rxd_i is already synchronised to clk_sys_i.
// Notes: A byte with a broken stop bit is dropped silently.
`timescale 1ns/10ps
module serial_rx_core
    import remote_trigger_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic rxd_i,
    output logic valid_o,
    output logic [7:0] data_o
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
    localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0] LAST_BIT = 4'(DATA_BITS);

    logic busy;
    logic [CW-1:0] cnt;
    logic [3:0] bit_idx;
    logic [7:0] shift;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= '0;
            bit_idx <= '0;
            shift <= '0;
            valid_o <= 1'b0;
            data_o <= '0;
        end else begin
            valid_o <= 1'b0;
            if (!busy) begin
                if (!rxd_i) begin
                    busy <= 1'b1;
                    cnt <= HALF;
                    bit_idx <= '0;
                end
            end else if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end else begin
                cnt <= FULL;
                bit_idx <= bit_idx + 1'b1;
                if (bit_idx == '0 && rxd_i) begin
                    busy <= 1'b0;
                end else if (bit_idx != '0 && bit_idx <= LAST_BIT) begin
                    shift <= {rxd_i, shift[7:1]};
                end else if (bit_idx > LAST_BIT) begin
                    busy <= 1'b0;
                    valid_o <= rxd_i;
                    data_o <= shift;
                end
            end
        end
    end
endmodule

// ===== verilog/serial_tx_core.sv
// Purpose: 8N1 transmitter with clear-to-send gating for the host serial port.
// Assumes: cts_i is synchronised and high when the host may receive.
// Notes: CTS is checked only before a frame starts; a frame in flight is never cut.
`timescale 1ns/10ps
module serial_tx_core
    import remote_trigger_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic cts_i,
    output logic ready_o,
    output logic txd_o
);
    localparam int CW = $clog2(BIT_CYCLES + 1);
    localparam int FRAME = 1 + DATA_BITS + STOP_BITS;
    localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);

    logic busy;
    logic [CW-1:0] cnt;
    logic [3:0] left;
    logic [FRAME-1:0] shift;

    assign ready_o = !busy && cts_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= '0;
            left <= '0;
            shift <= '1;
            txd_o <= 1'b1;
        end else if (!busy) begin
            txd_o <= 1'b1;
            if (valid_i && cts_i) begin
                busy <= 1'b1;
                shift <= {1'b1, data_i, 1'b0};
                cnt <= FULL;
                left <= 4'(FRAME - 1);
                txd_o <= 1'b0;
            end
        end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
        end else if (left == '0) begin
            busy <= 1'b0;
        end else begin
            cnt <= FULL;
            left <= left - 1'b1;
            shift <= {1'b1, shift[FRAME-1:1]};
            txd_o <= shift[1];
        end
    end
endmodule

// ===== verilog/remote_trigger_serial_port.sv
// Purpose: Remote trigger, gate sync, ready contact and host serial port of a torque meter.
// Assumes: Pins are contact levels, low meaning closed; samples arrive on the system clock.
// Notes: Command meaning is left to the user side; this block frames lines and replies.
//
// Summary of operation
// - Trigger open-to-closed edge updates display and data.
// - Trigger acts only under the external gate setting.
// - Gate sync output marks every internal gate update.
// - Externally gated, gate sync follows trigger events.
// - Ready contact closed while in measurement state.
// - Measure needs select, torque present, zero-clear open.
// - External gating reports mean between trigger events.
// - Serial link 9600 baud, 8 data, no parity, 1 stop.
// - Hardware flow control: RTS output, CTS input.
// - Every transmitted message ends with CR LF.
// - Setting command without parameter becomes a query.
// - Return code enabled by default after reset.
// - No new command until return code sent.
// - Return codes can be disabled by configuration.
// - Zero-clear closed forces outputs zero, blocks zeroing.
`timescale 1ns/10ps
module remote_trigger_serial_port
    import remote_trigger_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF,
    parameter int GATE_SHORT_CYCLES = GATE_SHORT_CYCLES_DEF,
    parameter int GATE_LONG_CYCLES = GATE_LONG_CYCLES_DEF,
    parameter int SYNC_CYCLES = SYNC_PULSE_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ext_trigger_input_i,
    input wire logic zero_clear_input_i,
    input wire logic measure_calibrate_select_i,
    input wire logic torque_signal_present_i,
    input wire gate_setting_t gate_setting_i,
    input wire logic return_code_disable_i,
    input wire logic sample_valid_i,
    input wire logic signed [SAMPLE_W-1:0] sample_i,
    output logic gate_sync_output_o,
    output logic ready_contact_o,
    output logic zero_correct_allow_o,
    output logic update_o,
    output reading_t reading_o,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic cts_i,
    output logic rts_o,
    output logic cmd_valid_o,
    output command_t cmd_o,
    input wire logic reply_valid_i,
    input wire logic [7:0] reply_byte_i,
    input wire logic reply_last_i,
    output logic reply_ready_o
);
    localparam int GCW = $clog2(GATE_LONG_CYCLES + 1);
    localparam int SCW = $clog2(SYNC_CYCLES + 1);

    // A sync pulse as long as a gate period would never fall between two gates.
    if (BIT_CYCLES < 4 || GATE_SHORT_CYCLES < 2 || GATE_LONG_CYCLES < GATE_SHORT_CYCLES ||
            SYNC_CYCLES < 1 || SYNC_CYCLES >= GATE_SHORT_CYCLES) begin
        $error("remote_trigger_serial_port: parameter out of range");
    end

    // Pin synchronisers: stage one feeds stage two only.
    logic [1:0] trig_sync;
    logic [1:0] clr_sync;
    logic [1:0] meas_sync;
    logic [1:0] trq_sync;
    logic [1:0] rxd_sync;
    logic [1:0] cts_sync;
    logic trig_prev;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            trig_sync <= 2'h3;
            clr_sync <= 2'h3;
            meas_sync <= 2'h0;
            trq_sync <= 2'h0;
            rxd_sync <= 2'h3;
            cts_sync <= 2'h0;
            trig_prev <= 1'b1;
        end else begin
            trig_sync <= {trig_sync[0], ext_trigger_input_i};
            clr_sync <= {clr_sync[0], zero_clear_input_i};
            meas_sync <= {meas_sync[0], measure_calibrate_select_i};
            trq_sync <= {trq_sync[0], torque_signal_present_i};
            rxd_sync <= {rxd_sync[0], rxd_i};
            cts_sync <= {cts_sync[0], cts_i};
            trig_prev <= trig_sync[1];
        end
    end

    wire trig = trig_sync[1];
    wire clr_closed = !clr_sync[1];
    wire ext_mode = (gate_setting_i == GATE_EXT);
    wire trig_fall = trig_prev && !trig;
    wire ext_event = trig_fall && ext_mode;

    // Measurement state and zero handling.
    wire measuring = meas_sync[1] && trq_sync[1] && !clr_closed;
    assign ready_contact_o = measuring;
    assign zero_correct_allow_o = !clr_closed;

    // Internal gate timer; it is held cleared while externally gated.
    logic [GCW-1:0] gate_cnt;
    wire [GCW-1:0] gate_last = (gate_setting_i == GATE_LONG) ?
        GCW'(GATE_LONG_CYCLES - 1) : GCW'(GATE_SHORT_CYCLES - 1);
    wire int_event = !ext_mode && (gate_cnt >= gate_last);
    wire gate_event = ext_mode ? ext_event : int_event;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || ext_mode || int_event) begin
            gate_cnt <= '0;
        end else begin
            gate_cnt <= gate_cnt + 1'b1;
        end
    end

    // Sync pulse stretched so that a slow relay contact sees it.
    logic [SCW-1:0] sync_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sync_cnt <= '0;
        end else if (gate_event) begin
            sync_cnt <= SCW'(SYNC_CYCLES);
        end else if (sync_cnt != '0) begin
            sync_cnt <= sync_cnt - 1'b1;
        end
    end
    assign gate_sync_output_o = (sync_cnt != '0);

    // Averaging over one gate period. The divide is combinational and long;
    // it is used once per gate, so a slow path is acceptable here.
    localparam int ACC_W = SAMPLE_W + COUNT_W;
    logic signed [ACC_W-1:0] acc;
    logic [COUNT_W-1:0] acc_n;
    wire signed [ACC_W-1:0] acc_div = signed'({{SAMPLE_W{1'b0}}, acc_n});
    wire signed [ACC_W-1:0] mean_full = (acc_n == '0) ? '0 : acc / acc_div;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || gate_event) begin
            acc <= '0;
            acc_n <= '0;
        end else if (sample_valid_i && acc_n != '1) begin
            acc <= acc + ACC_W'(sample_i);
            acc_n <= acc_n + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            update_o <= 1'b0;
            reading_o <= '0;
        end else begin
            update_o <= gate_event;
            if (clr_closed) begin
                reading_o.value <= '0;
                reading_o.forced_zero <= 1'b1;
            end else if (gate_event) begin
                reading_o.value <= mean_full[SAMPLE_W-1:0];
                reading_o.forced_zero <= 1'b0;
            end
        end
    end

    // Serial port.
    logic rx_valid;
    logic [7:0] rx_data;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;

    serial_rx_core #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .rxd_i(rxd_sync[1]),
        .valid_o(rx_valid),
        .data_o(rx_data)
    );

    serial_tx_core #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .valid_i(tx_valid),
        .data_i(tx_data),
        .cts_i(cts_sync[1]),
        .ready_o(tx_ready),
        .txd_o(txd_o)
    );

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_WAIT_USER,
        TX_USER,
        TX_CODE,
        TX_CR,
        TX_LF,
        TX_DRAIN
    } tx_state_t;

    tx_state_t state;
    tx_state_t next_state;
    logic saw_cr;
    logic [7:0] line_len;
    logic [MNEM_LEN*8-1:0] mnem;

    // Return codes are on unless configuration turns them off.
    wire rc_enable = !return_code_disable_i;
    wire busy = (state != TX_IDLE);
    wire rx_take = rx_valid && !busy;
    wire line_end = rx_take && saw_cr && rx_data == CHAR_LF;
    wire has_param = line_len > 8'(MNEM_LEN);
    wire is_query = !has_param;

    assign rts_o = !busy;
    assign reply_ready_o = (state == TX_USER) && tx_ready;

    always_comb begin
        next_state = state;
        unique case (state)
            TX_IDLE: begin
                if (line_end && is_query) begin
                    next_state = TX_WAIT_USER;
                end else if (line_end && rc_enable) begin
                    next_state = TX_CODE;
                end
            end
            TX_WAIT_USER: begin
                if (reply_valid_i) begin
                    next_state = TX_USER;
                end
            end
            TX_USER: begin
                if (reply_valid_i && tx_ready && reply_last_i) begin
                    next_state = TX_CR;
                end
            end
            TX_CODE: begin
                if (tx_ready) begin
                    next_state = TX_CR;
                end
            end
            TX_CR: begin
                if (tx_ready) begin
                    next_state = TX_LF;
                end
            end
            TX_LF: begin
                if (tx_ready) begin
                    next_state = TX_DRAIN;
                end
            end
            // The port stays closed until the final line feed has left the wire.
            TX_DRAIN: begin
                if (tx_ready) begin
                    next_state = TX_IDLE;
                end
            end
        endcase
    end

    assign tx_valid = (state == TX_USER && reply_valid_i) || state == TX_CODE ||
        state == TX_CR || state == TX_LF;
    assign tx_data = (state == TX_CODE) ? RC_OK :
        (state == TX_CR) ? CHAR_CR :
        (state == TX_LF) ? CHAR_LF : reply_byte_i;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state <= TX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Line assembly; bytes arriving while a reply is owed are dropped.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            saw_cr <= 1'b0;
            line_len <= '0;
            mnem <= '0;
            cmd_valid_o <= 1'b0;
            cmd_o <= '0;
        end else begin
            cmd_valid_o <= 1'b0;
            if (line_end) begin
                cmd_valid_o <= 1'b1;
                cmd_o.mnemonic <= mnem;
                cmd_o.has_param <= has_param;
                saw_cr <= 1'b0;
                line_len <= '0;
                mnem <= '0;
            end else if (rx_take) begin
                saw_cr <= (rx_data == CHAR_CR);
                if (rx_data != CHAR_CR && rx_data != CHAR_LF) begin
                    if (line_len < 8'(MNEM_LEN)) begin
                        mnem <= {mnem[(MNEM_LEN-1)*8-1:0], rx_data};
                    end
                    if (line_len != LINE_LEN_MAX) begin
                        line_len <= line_len + 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ===== verification/rtsp_props.sv
// Purpose: Port checks of the remote trigger and serial port.
// Assumes: Pins pass two synchroniser stages before the logic sees them.
// Notes: Counts follow the parameters handed on by the bind; the sync pulse check uses a fixed 9 cycles.
`timescale 1ns/10ps
module rtsp_props
    import remote_trigger_pkg::*;
#(
    parameter int BIT_CYCLES = BIT_CYCLES_DEF,
    parameter int GATE_SHORT_CYCLES = GATE_SHORT_CYCLES_DEF,
    parameter int GATE_LONG_CYCLES = GATE_LONG_CYCLES_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ext_trigger_input_i,
    input wire logic zero_clear_input_i,
    input wire logic measure_calibrate_select_i,
    input wire logic torque_signal_present_i,
    input wire gate_setting_t gate_setting_i,
    input wire logic return_code_disable_i,
    input wire logic gate_sync_output_o,
    input wire logic ready_contact_o,
    input wire logic zero_correct_allow_o,
    input wire logic update_o,
    input wire reading_t reading_o,
    input wire logic txd_o,
    input wire logic cts_i,
    input wire logic rts_o,
    input wire logic cmd_valid_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    logic trig_q, tx_q;
    gate_setting_t gs_q;
    int age, gap, run, txc;
    // A frame starts only when the line falls outside a frame already being counted.
    wire start = txc == 0 && tx_q && !txd_o;
    wire trig_fall = trig_q && !ext_trigger_input_i;
    wire meas = measure_calibrate_select_i && torque_signal_present_i && zero_clear_input_i;
    wire [31:0] per = gate_setting_i == GATE_SHORT ? GATE_SHORT_CYCLES : GATE_LONG_CYCLES;
    wire [31:0] next_txc = start ? 10 * BIT_CYCLES - 1 : (txc == 0 ? 0 : txc - 1);
    wire [31:0] next_age = trig_fall ? 0 : (age < 99 ? age + 1 : age);
    wire [31:0] next_run = (rst_i || gs_q != gate_setting_i) ? 0 : run + 1;
    always_ff @(posedge clk_sys_i) begin
        trig_q <= ext_trigger_input_i;
        tx_q <= txd_o;
        gs_q <= gate_setting_i;
        age <= next_age;
        gap <= update_o ? 1 : gap + 1;
        run <= next_run;
        txc <= rst_i ? 0 : next_txc;
    end
    trig_upd_a:
    assert property (trig_fall && gate_setting_i == GATE_EXT && run > 8 |-> ##[3:5] update_o)
        else $error("no update after trigger");
    ext_only_a:
    assert property (update_o && gate_setting_i == GATE_EXT && run > 8 |-> age >= 2 && age <= 4)
        else $error("external update without trigger");
    gate_per_a:
    assert property (update_o && gate_setting_i != GATE_EXT && run > 2 * per |-> gap == per)
        else $error("internal gate period wrong");
    sync_upd_a:
    assert property (update_o |-> gate_sync_output_o) else $error("update without sync");
    sync_pulse_a:
    assert property ($rose(gate_sync_output_o) |-> update_o ##1 gate_sync_output_o [*8])
        else $error("sync pulse wrong");
    ready_on_a:
    assert property (meas [*4] |-> ready_contact_o) else $error("ready contact open");
    ready_off_a:
    assert property ((!meas) [*4] |-> !ready_contact_o) else $error("ready contact closed");
    zero_force_a:
    assert property ((!zero_clear_input_i) [*4] |-> reading_o.value == '0
        && reading_o.forced_zero && !zero_correct_allow_o) else $error("zero clear ignored");
    cts_hold_a:
    assert property ((!cts_i) [*6] |-> !start) else $error("frame started without cts");
    tx_frame_a:
    assert property (txc != 0 && (txc <= BIT_CYCLES || txc > 9 * BIT_CYCLES)
        |-> txd_o == (txc <= BIT_CYCLES)) else $error("start or stop bit wrong");
    busy_rts_a:
    assert property (cmd_valid_o && !return_code_disable_i |-> ##1 (!rts_o) [*8])
        else $error("commands accepted while reply pending");
endmodule
bind remote_trigger_serial_port rtsp_props #(.BIT_CYCLES(BIT_CYCLES),
    .GATE_SHORT_CYCLES(GATE_SHORT_CYCLES), .GATE_LONG_CYCLES(GATE_LONG_CYCLES)) u_props (
    .clk_sys_i, .rst_i, .ext_trigger_input_i, .zero_clear_input_i,
    .measure_calibrate_select_i, .torque_signal_present_i, .gate_setting_i,
    .return_code_disable_i, .gate_sync_output_o, .ready_contact_o,
    .zero_correct_allow_o, .update_o, .reading_o, .txd_o, .cts_i, .rts_o, .cmd_valid_o);

// ===== verification/host_model.sv
// Purpose: Host end of the serial port: sends lines and collects replies.
// Assumes: Both ends share the bit time in clock cycles.
// Notes: A received byte with a broken stop bit is dropped, as a real port would.
`timescale 1ns/10ps
module host_model #(
    parameter int BIT_CYCLES = 16
) (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic rts_i,
    input wire logic stall_i,
    output logic rxd_o,
    output logic cts_o
);
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    assign cts_o = !stall_i;
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] b);
        wait (rts_i === 1'b1);
        @(negedge clk_i);
        rxd_o = 1'b0;
        repeat (BIT_CYCLES) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            rxd_o = b[i];
            repeat (BIT_CYCLES) @(negedge clk_i);
        end
        rxd_o = 1'b1;
        repeat (BIT_CYCLES) @(negedge clk_i);
    endtask
    initial forever begin
        @(negedge txd_i);
        repeat (BIT_CYCLES / 2) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(negedge clk_i);
            sh[i] = txd_i;
        end
        repeat (BIT_CYCLES) @(negedge clk_i);
        if (txd_i === 1'b1) rx_q.push_back(sh);
    end
endmodule

// ===== verification/tb.sv
// Purpose: Self-checking bench of the remote trigger and serial port.
// Assumes: Gate periods and bit time are scaled down for simulation.
// Notes: Inputs change on the falling clock edge and outputs are read there.
`timescale 1ns/10ps
module tb;
    import remote_trigger_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic ext_trigger_input_i = 1'b1;
    logic zero_clear_input_i = 1'b1;
    logic measure_calibrate_select_i = 1'b1;
    logic torque_signal_present_i = 1'b1;
    gate_setting_t gate_setting_i = GATE_EXT;
    logic return_code_disable_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic signed [SAMPLE_W-1:0] sample_i = '0;
    logic reply_valid_i = 1'b0;
    logic [7:0] reply_byte_i = 8'h00;
    logic reply_last_i = 1'b0;
    logic stall = 1'b0;
    logic gate_sync_output_o, ready_contact_o, zero_correct_allow_o, update_o;
    logic rxd_i, txd_o, cts_i, rts_o, cmd_valid_o, reply_ready_o;
    reading_t reading_o;
    command_t cmd_o, last_cmd;
    int err_count = 0;
    int checks = 0;
    int ncmd = 0;
    remote_trigger_serial_port #(.BIT_CYCLES(16), .GATE_SHORT_CYCLES(50), .SYNC_CYCLES(10),
        .GATE_LONG_CYCLES(200)) u_dut (.clk_sys_i, .rst_i, .ext_trigger_input_i,
        .zero_clear_input_i, .measure_calibrate_select_i, .torque_signal_present_i,
        .gate_setting_i, .return_code_disable_i, .sample_valid_i, .sample_i,
        .gate_sync_output_o, .ready_contact_o, .zero_correct_allow_o, .update_o, .reading_o,
        .rxd_i, .txd_o, .cts_i, .rts_o, .cmd_valid_o, .cmd_o, .reply_valid_i, .reply_byte_i,
        .reply_last_i, .reply_ready_o);
    host_model #(.BIT_CYCLES(16)) u_host (.clk_i(clk_sys_i), .txd_i(txd_o), .rts_i(rts_o),
        .stall_i(stall), .rxd_o(rxd_i), .cts_o(cts_i));
    always #5 clk_sys_i = !clk_sys_i;
    // Command pulses last one cycle, so they are latched here for the scenarios.
    always @(posedge clk_sys_i) begin
        if (cmd_valid_o === 1'b1) begin
            last_cmd <= cmd_o;
            ncmd <= ncmd + 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic wait_upd(input int lim, output int n);
        n = 0;
        do begin
            tick(1);
            n++;
        end while (update_o !== 1'b1 && n < lim);
    endtask
    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++) u_host.send(s[i]);
        u_host.send(CHAR_CR);
        u_host.send(CHAR_LF);
    endtask
    task automatic wait_cmd(input int n0);
        int n;
        n = 0;
        while (ncmd == n0 && n < 100) begin
            tick(1);
            n++;
        end
        chk(ncmd, n0 + 1, "line taken");
    endtask
    task automatic reply(input logic [7:0] b);
        int n;
        n = 0;
        reply_byte_i = b;
        reply_last_i = 1'b1;
        reply_valid_i = 1'b1;
        do begin
            tick(1);
            n++;
        end while (reply_ready_o !== 1'b1 && n < 2000);
        @(negedge clk_sys_i);
        reply_valid_i = 1'b0;
        reply_last_i = 1'b0;
        chk(n < 2000, 1'b1, "reply taken");
    endtask
    task automatic rx3(input logic [7:0] b0);
        int n;
        n = 0;
        while (u_host.rx_q.size() < 3 && n < 3000) begin
            tick(1);
            n++;
        end
        chk(u_host.rx_q.size(), 3, "reply length");
        chk(u_host.rx_q[0], b0, "reply byte");
        chk(u_host.rx_q[1], CHAR_CR, "cr");
        chk(u_host.rx_q[2], CHAR_LF, "lf");
        u_host.rx_q.delete();
        tick(16);
    endtask
    task automatic t_ready();
        for (int i = 0; i < 8; i++) begin
            {measure_calibrate_select_i, torque_signal_present_i, zero_clear_input_i} = i[2:0];
            tick(4);
            chk(ready_contact_o, i == 7, "ready");
        end
    endtask
    task automatic t_gate();
        int n;
        gate_setting_i = GATE_SHORT;
        wait_upd(300, n);
        wait_upd(300, n);
        chk(n, 50, "short gate");
        chk(gate_sync_output_o, 1'b1, "sync");
        tick(12);
        chk(gate_sync_output_o, 1'b0, "sync ends");
        gate_setting_i = GATE_LONG;
        for (int i = 0; i < 3; i++) wait_upd(300, n);
        chk(n, 200, "long gate");
        ext_trigger_input_i = 1'b0;
        wait_upd(30, n);
        chk(n, 30, "trigger ignored");
        ext_trigger_input_i = 1'b1;
    endtask
    task automatic t_ext();
        int n;
        int s[4] = '{3, 5, 7, -1};
        gate_setting_i = GATE_EXT;
        tick(20);
        // Trigger steps stand in for a master's sync contact, with the spacing scaled down.
        ext_trigger_input_i = 1'b0;
        wait_upd(10, n);
        chk(n >= 3 && n <= 5, 1'b1, "trigger edge");
        ext_trigger_input_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            sample_i = SAMPLE_W'(s[i]);
            sample_valid_i = 1'b1;
            tick(1);
            sample_valid_i = 1'b0;
            tick(1);
        end
        tick(10);
        ext_trigger_input_i = 1'b0;
        wait_upd(10, n);
        chk(reading_o, {24'd3, 1'b0}, "mean");
        chk(gate_sync_output_o, 1'b1, "sync");
        ext_trigger_input_i = 1'b1;
    endtask
    task automatic t_zero();
        int n;
        gate_setting_i = GATE_SHORT;
        zero_clear_input_i = 1'b0;
        tick(5);
        wait_upd(100, n);
        chk(reading_o, 25'h1, "forced zero");
        chk(zero_correct_allow_o, 1'b0, "no zeroing");
        chk(ready_contact_o, 1'b0, "not measuring");
        zero_clear_input_i = 1'b1;
        tick(5);
    endtask
    task automatic t_query();
        int n0;
        n0 = ncmd;
        send_line("ABC");
        wait_cmd(n0);
        chk(last_cmd, {"ABC", 1'b0}, "query");
        chk(rts_o, 1'b0, "busy");
        reply(8'h35);
        rx3(8'h35);
        chk(rts_o, 1'b1, "free");
    endtask
    task automatic t_set();
        int n0;
        n0 = ncmd;
        stall = 1'b1;
        send_line("ABC1");
        wait_cmd(n0);
        chk(last_cmd.has_param, 1'b1, "setting");
        tick(400);
        chk(u_host.rx_q.size(), 0, "cts stall");
        stall = 1'b0;
        rx3(RC_OK);
        return_code_disable_i = 1'b1;
        n0 = ncmd;
        send_line("ABC2");
        wait_cmd(n0);
        tick(600);
        chk(u_host.rx_q.size(), 0, "no code");
        chk(rts_o, 1'b1, "free");
    endtask
    initial begin
        tick(2);
        rst_i = 1'b0;
        tick(3);
        t_ready();
        t_gate();
        t_ext();
        t_zero();
        t_query();
        t_set();
        close_out();
    end
    initial begin
        tick(30000);
        err_count++;
        close_out();
    end
endmodule
